// [dv/hline_source.sv]
// horizontal timing model feeding the vertical chain
// assumes one character per clock and a fixed line length
`timescale 1ns/100ps
`default_nettype none
module hline_source
    import vtiming_pkg::*;
#(parameter int LINE = 16)
(
    input  wire logic              hclk,           // character clock
    input  wire logic              hresetn,        // async reset, low
    output logic                   line_end,       // last char of line
    output logic                   hblank_begin,   // hblank start
    output logic [ADDR_W-1:0]      char_addr,      // char position
    output logic                   underline_attr, // one char underlined
    output logic [2:0]             dot_index       // dot in cell
);
    logic [ADDR_W-1:0] pos_reg = '0;
    // free-running position so every scan line has equal length
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pos_reg <= '0;
        else pos_reg <= line_end ? '0 : pos_reg + 16'h0001;
    end
    assign line_end = pos_reg == 16'(LINE - 1);
    assign hblank_begin = pos_reg == 16'h000A;  // after the shown chars
    assign char_addr = pos_reg;
    assign underline_attr = pos_reg == 16'h0009;
    assign dot_index = pos_reg[2:0];
endmodule
`default_nettype wire

// [dv/vertical_chain_checker.sv]
// port-level assertions for the vertical timing chain
// assumes it is bound to vertical_chain with all pins named
`timescale 1ns/100ps
`default_nettype none
module vertical_chain_checker (
    input wire logic       hclk,            // character clock
    input wire logic       hresetn,         // async reset, low
    input wire logic       line_end,        // line end pulse
    input wire logic       hblank_begin,    // hblank pulse
    input wire logic       underline_attr,  // underline selected
    input wire logic       vsync_n,         // vertical sync, low
    input wire logic       frame_start,     // frame pulse
    input wire logic       underline_video, // underline out
    input wire logic       blink_slow,      // slow blink
    input wire logic [1:0] gfx_column,      // block column
    input wire logic [1:0] gfx_row          // block row
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // sync edges only just after horizontal blanking starts
    a_sync_fall: assert property ($fell(vsync_n) |->
        $past(hblank_begin) || $past(hblank_begin, 2)) else $error("bad fall");
    a_sync_rise: assert property ($rose(vsync_n) |->
        $past(hblank_begin) || $past(hblank_begin, 2)) else $error("bad rise");
    a_frame_pulse: assert property (frame_start |=> !frame_start)
        else $error("long frame pulse");
    a_frame_cause: assert property (frame_start |->
        $past(line_end) || $past(line_end, 2)) else $error("frame no line");
    a_ul_attr: assert property (underline_video |->
        $past(underline_attr)) else $error("underline no attr");
    a_col_legal: assert property (gfx_column != 2'h3)
        else $error("bad column");
    a_row_legal: assert property (gfx_row != 2'h3)
        else $error("bad row");
    // divider only steps while sync is active
    a_slow_step: assert property ($changed(blink_slow) |->
        !vsync_n || !$past(vsync_n)) else $error("blink off sync");
endmodule
bind vertical_chain vertical_chain_checker chk (.hclk, .hresetn,
    .line_end, .hblank_begin, .underline_attr, .vsync_n, .frame_start,
    .underline_video, .blink_slow, .gfx_column, .gfx_row);
`default_nettype wire

// [dv/vertical_chain_test.sv]
// self-checking bench for the vertical chain over ahb-lite
// assumes hline_source supplies 16-char lines
`timescale 1ns/100ps
`default_nettype none
module vertical_chain_test
    import vtiming_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0] htrans = 2'h0, gfx_column, gfx_row;
    logic [2:0] hsize = 3'h0, dot_index;
    logic [ADDR_W-1:0] char_addr;
    logic hreadyout, hresp, line_end, hblank_begin, underline_attr, vblank;
    logic vsync_n, status_row, frame_start, cursor_video, underline_video;
    logic blink, blink_slow;
    int err_count = 0, comparisons = 0;
    logic [15:0] cnt [9] = '{default: 16'h0}, snap [9];
    // legal software values: middle row nonzero, extra equal to height so no extra scans
    logic [31:0] cfg [4:14] = '{32'h33, 32'h05, 32'h03, 32'h13, 32'h02,
        32'h04, 32'h24, 32'h12, 32'h22, 32'h12, 32'h05};
    logic [31:0] msk [4:14] = '{32'hFF, 32'h1F, 32'h1F, 32'hFF, 32'h1F,
        32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFFFF};
    logic [31:0] syn [3] = '{32'h13, 32'h22, 32'h31};
    logic [31:0] vs_exp [3] = '{32'h20, 32'h0, 32'h20};
    wire logic [8:0] inc = {blink, gfx_row == 2'h2, gfx_column == 2'h2,
        line_end, ~vsync_n, vblank, status_row,
        cursor_video, underline_video};
    always #2.5 hclk = ~hclk;
    vertical_chain uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .line_end, .hblank_begin, .char_addr, .underline_attr, .dot_index,
        .vblank, .vsync_n, .status_row, .frame_start, .cursor_video,
        .underline_video, .blink, .blink_slow, .gfx_column, .gfx_row);
    hline_source #(.LINE(16)) hsrc (.hclk, .hresetn, .line_end,
        .hblank_begin, .char_addr, .underline_attr, .dot_index);
    // per-frame event counts, window closes on the frame pulse
    always @(posedge hclk) begin
        for (int k = 0; k < 9; k++) begin
            if (frame_start === 1'b1) snap[k] <= cnt[k] + 16'(inc[k]);
            cnt[k] <= (frame_start === 1'b1) ? 16'h0 : cnt[k] + 16'(inc[k]);
        end
    end
    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a hang counts as a failure
    initial begin
        #100000;
        err_count++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            xfer(1'b0, 32'(i * 4), 32'h0);
            check("reset", rd, 32'h0);
            check("okay", {31'h0, hresp}, 32'h0);
        end
        xfer(1'b1, 32'h0, 32'hFFFFFFFF);
        xfer(1'b0, 32'h0, 32'h0);
        check("unmapped", rd, 32'h0);
        for (int i = 4; i < 15; i++) xfer(1'b1, 32'(i * 4), cfg[i] | ~msk[i]);
        for (int i = 4; i < 15; i++) begin
            xfer(1'b0, 32'(i * 4), 32'h0);
            check("readback", rd, cfg[i]);
        end
        // 6 rows of 4 lines, rows 4..5 blanked
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 32'h1C, syn[k]);
            repeat (2) @(posedge frame_start);
            repeat (2) @(negedge hclk);
            check("lines", {16'h0, snap[5]}, 32'h18);
            check("sync", {16'h0, snap[4]}, vs_exp[k]);
            check("blank", {16'h0, snap[3]}, 32'h80);
            check("status", {16'h0, snap[2]}, 32'h40);
            check("cursor", {16'h0, snap[1]}, 32'h8);
            check("underline", {16'h0, snap[0]}, 32'h4);
            check("bottom", {16'h0, snap[7]}, 32'hC0);
            check("column", {16'h0, snap[6]}, 32'h90);
            check("blink", {16'h0, snap[8]}, 32'h180);
        end
        close_out;
    end
endmodule
`default_nettype wire

// [logic/blink_divider.sv]
// blink divider stepped by vertical sync pulses
// assumes vsync_tick is a one-cycle pulse per vertical sync start
`timescale 1ns/100ps
`default_nettype none

module blink_divider
    import vtiming_pkg::*;
(
    input  wire logic       hclk,        // character clock
    input  wire logic       hresetn,     // async reset, active low
    input  wire blink_cfg_s cfg,         // divisor and duty code
    input  wire logic       vsync_tick,  // one pulse per frame
    output logic            blink,       // duty-shaped blink level
    output logic            blink_slow   // half of blink rate
);

    // ------------------------------------------------------------
    // divider state
    // ------------------------------------------------------------
    logic [RATE_W-1:0] cnt_reg;
    logic              terminal;
    logic [8:0]        on_limit;
    logic [8:0]        phase_x8;

    // on while cnt*8 < (duty+1)*(rate+1); 011 gives exactly half duty when rate is odd
    assign terminal = (cnt_reg == cfg.rate);
    assign on_limit = 9'((cfg.duty + 4'h1) * (cfg.rate + 6'h01));
    assign phase_x8 = {1'b0, cnt_reg, 3'h0};

    // advance on each sync pulse, reload at the terminal count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg    <= '0;
            blink_slow <= 1'b0;
        end else if (vsync_tick) begin
            cnt_reg    <= terminal ? '0 : cnt_reg + 1'b1;
            blink_slow <= terminal ? ~blink_slow : blink_slow;
        end
    end

    // duty output registered so it stays glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink <= 1'b0;
        end else begin
            blink <= (phase_x8 < on_limit);
        end
    end

endmodule

`default_nettype wire

// [logic/vertical_chain.sv]
// vertical timing chain with cursor, underline and block graphics controls
// assumes horizontal timing supplies line_end and hblank_begin pulses on
// the character clock, and an ahb-lite master for the register file
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module vertical_chain
    import vtiming_pkg::*;
(
    input  wire logic              hclk,           // character clock
    input  wire logic              hresetn,        // async reset, low
    input  wire logic              hsel,           // slave select
    input  wire logic [31:0]       haddr,          // byte address
    input  wire logic [1:0]        htrans,         // transfer type
    input  wire logic              hwrite,         // write when high
    input  wire logic [2:0]        hsize,          // transfer size
    input  wire logic [31:0]       hwdata,         // write data
    input  wire logic              hready,         // bus ready in
    output logic                   hreadyout,      // slave ready
    output logic [31:0]            hrdata,         // read data
    output logic                   hresp,          // always okay
    input  wire logic              line_end,       // last char of line
    input  wire logic              hblank_begin,   // hblank start pulse
    input  wire logic [ADDR_W-1:0] char_addr,      // shown char address
    input  wire logic              underline_attr, // underline selected
    input  wire logic [2:0]        dot_index,      // dot in cell
    output logic                   vblank,         // vertical blanking
    output logic                   vsync_n,        // vertical sync, low
    output logic                   status_row,     // status row shown
    output logic                   frame_start,    // new frame pulse
    output logic                   cursor_video,   // cursor inserted
    output logic                   underline_video,// underline inserted
    output logic                   blink,          // blink level
    output logic                   blink_slow,     // slow blink level
    output logic [1:0]             gfx_column,     // 0 left 1 mid 2 right
    output logic [1:0]             gfx_row         // 0 top 1 mid 2 bottom
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // column index: count of boundary bits 1..7 set at or below the dot, capped at 2
    function automatic logic [1:0] column_of(input logic [7:0] map,
                                             input logic [2:0] dot);
        logic [1:0] col;
        col = 2'h0;
        for (int i = 1; i < 8; i++) begin
            if ((i <= int'(dot)) && map[i] && (col != 2'h2)) begin
                col = col + 2'h1;
            end
        end
        return col;
    endfunction

    // next state of a begin/end scan flip-flop at a line boundary
    function automatic logic range_ff(input logic       cur,
                                      input logic [7:0] range,
                                      input logic [3:0] old_scan,
                                      input logic [3:0] new_scan);
        logic v;
        v = cur;
        if (old_scan == range[3:0]) begin
            v = 1'b0;
        end
        if (new_scan == range[7:4]) begin
            v = 1'b1;
        end
        return v;
    endfunction

    // row compare with one added, safe at the top of the range
    function automatic logic row_after(input logic [ROW_W-1:0] row,
                                       input logic [ROW_W-1:0] ref_row);
        return ({1'b0, row} == ({1'b0, ref_row} + 6'h01));
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0]        cell_reg;       // height high, extra scans low
    logic [ROW_W-1:0]  frame_len_reg;
    logic [ROW_W-1:0]  blank_row_reg;
    logic [7:0]        vsync_reg;      // begin high, end low
    logic [ROW_W-1:0]  status_pos_reg;
    logic [7:0]        blink_cfg_reg;
    logic [7:0]        gcol_reg;
    logic [7:0]        grow_reg;
    logic [7:0]        ul_reg;
    logic [7:0]        cur_reg;
    logic [ADDR_W-1:0] cursor_address_addr_reg;
    logic [15:0]       chain_status;   // read-only position word

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    logic       wr_pend_reg;
    logic [3:0] wr_idx_reg;
    logic       addr_phase;
    logic [3:0] a_idx;
    logic       a_word;
    logic [31:0] rd_value;
    logic [31:0] rd_mux;

    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign a_idx      = haddr[IDX_LSB +: 4];
    assign a_word     = (hsize == HSIZE_WORD) && (haddr[31:6] == 26'h0);

    // register read decode; unmapped words read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (a_idx)
            IDX_CELL_SCAN_HEIGHT:     rd_value[7:0] = cell_reg;
            IDX_FRAME_ROW_LENGTH:     rd_value[4:0] = frame_len_reg;
            IDX_VERTICAL_BLANK_ROW:   rd_value[4:0] = blank_row_reg;
            IDX_VSYNC_BEGIN_END:      rd_value[7:0] = vsync_reg;
            IDX_STATUS_ROW_POSITION:  rd_value[4:0] = status_pos_reg;
            IDX_BLINK_RATE_DUTY:      rd_value[7:0] = blink_cfg_reg;
            IDX_BLOCK_GRAPHICS_COLS:  rd_value[7:0] = gcol_reg;
            IDX_BLOCK_GRAPHICS_ROWS:  rd_value[7:0] = grow_reg;
            IDX_UNDERLINE_SCAN_RANGE: rd_value[7:0] = ul_reg;
            IDX_CURSOR_SCAN_RANGE:    rd_value[7:0] = cur_reg;
            IDX_CURSOR_ADDRESS:       rd_value[15:0] = cursor_address_addr_reg;
            IDX_CHAIN_STATUS:         rd_value[15:0] = chain_status;
            default:                  rd_value = 32'h0000_0000;
        endcase
    end

    // a read right behind a write to the same word sees the new data
    assign rd_mux = (wr_pend_reg && (wr_idx_reg == a_idx))
                    ? (hwdata & rd_mask(a_idx)) : rd_value;

    // field mask per word, so forwarded data matches the stored width
    function automatic logic [31:0] rd_mask(input logic [3:0] idx);
        logic [31:0] m;
        m = 32'h0000_00FF;
        if ((idx == IDX_FRAME_ROW_LENGTH) || (idx == IDX_VERTICAL_BLANK_ROW)
            || (idx == IDX_STATUS_ROW_POSITION)) begin
            m = 32'h0000_001F;
        end else if (idx == IDX_CURSOR_ADDRESS) begin
            m = 32'h0000_FFFF;
        end else if ((idx == IDX_CHAIN_STATUS) || (idx < IDX_CELL_SCAN_HEIGHT)) begin
            m = 32'h0000_0000;
        end
        return m;
    endfunction

    // address phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 4'h0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b0;
            hresp       <= HRESP_OKAY;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= HRESP_OKAY;
            wr_pend_reg <= addr_phase && hwrite && a_word;
            wr_idx_reg  <= a_idx;
            if (addr_phase && !hwrite) begin
                hrdata <= a_word ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // data phase write into the addressed word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_reg       <= RST_BYTE;
            frame_len_reg  <= RST_ROW;
            blank_row_reg  <= RST_ROW;
            vsync_reg      <= RST_BYTE;
            status_pos_reg <= RST_ROW;
            blink_cfg_reg  <= RST_BYTE;
            gcol_reg       <= RST_BYTE;
            grow_reg       <= RST_BYTE;
            ul_reg         <= RST_BYTE;
            cur_reg        <= RST_BYTE;
            cursor_address_addr_reg  <= RST_ADDR;
        end else if (wr_pend_reg) begin
            unique case (wr_idx_reg)
                IDX_CELL_SCAN_HEIGHT:     cell_reg <= hwdata[7:0];
                IDX_FRAME_ROW_LENGTH:     frame_len_reg <= hwdata[4:0];
                IDX_VERTICAL_BLANK_ROW:   blank_row_reg <= hwdata[4:0];
                IDX_VSYNC_BEGIN_END:      vsync_reg <= hwdata[7:0];
                IDX_STATUS_ROW_POSITION:  status_pos_reg <= hwdata[4:0];
                IDX_BLINK_RATE_DUTY:      blink_cfg_reg <= hwdata[7:0];
                IDX_BLOCK_GRAPHICS_COLS:  gcol_reg <= hwdata[7:0];
                IDX_BLOCK_GRAPHICS_ROWS:  grow_reg <= hwdata[7:0];
                IDX_UNDERLINE_SCAN_RANGE: ul_reg <= hwdata[7:0];
                IDX_CURSOR_SCAN_RANGE:    cur_reg <= hwdata[7:0];
                IDX_CURSOR_ADDRESS:       cursor_address_addr_reg <= hwdata[15:0];
                default:                  cell_reg <= cell_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // row and scan counters
    // ------------------------------------------------------------
    frame_phase_e      phase_reg;
    frame_phase_e      phase_next;
    logic [ROW_W-1:0]  row_reg;
    logic [ROW_W-1:0]  row_next;
    logic [SCAN_W-1:0] scan_reg;
    logic [SCAN_W-1:0] scan_next;
    logic              wrap_next;

    logic [3:0] height;
    logic [3:0] extra;
    logic [3:0] vs_begin;
    logic [3:0] vs_end;
    assign height   = cell_reg[NIB_HI_LSB +: 4];
    assign extra    = cell_reg[3:0];
    assign vs_begin = vsync_reg[NIB_HI_LSB +: 4];
    assign vs_end   = vsync_reg[3:0];

    // scan wraps at cell height in rows and at extra in the extra scans, so a compare above both never matches
    always_comb begin
        phase_next = phase_reg;
        row_next   = row_reg;
        scan_next  = scan_reg + 4'h1;
        wrap_next  = 1'b0;
        unique case (phase_reg)
            ST_ROWS: begin
                if (scan_reg == height) begin
                    scan_next = 4'h0;
                    if (row_reg == frame_len_reg) begin
                        row_next   = RST_ROW;
                        wrap_next  = (extra == height);
                        phase_next = wrap_next ? ST_ROWS : ST_EXTRA;
                    end else begin
                        row_next = row_reg + 5'h01;
                    end
                end
            end
            ST_EXTRA: begin
                if (scan_reg == extra) begin
                    scan_next  = 4'h0;
                    wrap_next  = 1'b1;
                    phase_next = ST_ROWS;
                end
            end
        endcase
    end

    // counters step at the end of every scan line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= ST_ROWS;
            row_reg   <= RST_ROW;
            scan_reg  <= 4'h0;
        end else if (line_end) begin
            phase_reg <= phase_next;
            row_reg   <= row_next;
            scan_reg  <= scan_next;
        end
    end

    assign chain_status = {5'h00, phase_reg == ST_EXTRA, row_reg,
                           1'b0, scan_reg};

    // ------------------------------------------------------------
    // blanking, sync and status row
    // ------------------------------------------------------------
    logic in_rows;
    logic blank_now;
    logic sync_on;
    logic vs_begin_hit;
    logic vs_end_hit;

    assign in_rows   = (phase_reg == ST_ROWS);
    assign blank_now = !in_rows || (row_reg > blank_row_reg);
    assign sync_on   = (vs_begin != vs_end);

    // begin line: normally in first blank row, else last displayed line
    assign vs_begin_hit = hblank_begin && sync_on && vsync_n && in_rows &&
        ((vs_begin == height)
            ? ((row_reg == blank_row_reg) && (scan_reg == height))
            : (row_after(row_reg, blank_row_reg)
               && (scan_reg == vs_begin)));
    assign vs_end_hit = hblank_begin && !vsync_n && (scan_reg == vs_end);

    // registering the hits gives the one char time after hblank
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vblank      <= 1'b0;
            vsync_n     <= 1'b1;
            status_row  <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            vblank      <= blank_now;
            vsync_n     <= vs_begin_hit ? 1'b0 : (vs_end_hit ? 1'b1 : vsync_n);
            status_row  <= in_rows && row_after(row_reg, status_pos_reg);
            frame_start <= line_end && wrap_next;
        end
    end

    // ------------------------------------------------------------
    // cursor and underline scan flip-flops
    // ------------------------------------------------------------
    logic cur_ff_reg;
    logic ul_ff_reg;
    logic at_cursor;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff_reg <= 1'b0;
            ul_ff_reg  <= 1'b0;
        end else if (line_end) begin
            cur_ff_reg <= range_ff(cur_ff_reg, cur_reg, scan_reg, scan_next);
            ul_ff_reg  <= range_ff(ul_ff_reg, ul_reg, scan_reg, scan_next);
        end
    end

    assign at_cursor = (char_addr == cursor_address_addr_reg);

    // video inserts, gated off during vertical blanking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cursor_video    <= 1'b0;
            underline_video <= 1'b0;
        end else begin
            cursor_video    <= at_cursor && cur_ff_reg && !blank_now;
            underline_video <= underline_attr && ul_ff_reg && !blank_now;
        end
    end

    // ------------------------------------------------------------
    // block graphics partitions
    // ------------------------------------------------------------
    logic [1:0] col_now;
    logic [1:0] row_part;

    assign col_now  = column_of(gcol_reg, dot_index);
    assign row_part = (scan_reg >= grow_reg[3:0]) ? 2'h2 :
                      ((scan_reg >= grow_reg[NIB_HI_LSB +: 4]) ? 2'h1 : 2'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gfx_column <= 2'h0;
            gfx_row    <= 2'h0;
        end else begin
            gfx_column <= col_now;
            gfx_row    <= row_part;
        end
    end

    // ------------------------------------------------------------
    // blink divider, stepped at each sync start
    // ------------------------------------------------------------
    logic vs_tick_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vs_tick_reg <= 1'b0;
        end else begin
            vs_tick_reg <= vs_begin_hit;
        end
    end

    blink_divider u_blink (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .cfg        (blink_cfg_reg),
        .vsync_tick (vs_tick_reg),
        .blink      (blink),
        .blink_slow (blink_slow)
    );

endmodule

`default_nettype wire

// [logic/vertical_chain_notes_unused.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [logic/vtiming_pkg.sv]
// constants, register map and carrier types of the vertical timing chain
// assumes a 32-bit ahb-lite slave with one aligned word per register
package vtiming_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CELL_SCAN_HEIGHT     = 4'h4;
    localparam logic [3:0] IDX_FRAME_ROW_LENGTH     = 4'h5;
    localparam logic [3:0] IDX_VERTICAL_BLANK_ROW   = 4'h6;
    localparam logic [3:0] IDX_VSYNC_BEGIN_END      = 4'h7;
    localparam logic [3:0] IDX_STATUS_ROW_POSITION  = 4'h8;
    localparam logic [3:0] IDX_BLINK_RATE_DUTY      = 4'h9;
    localparam logic [3:0] IDX_BLOCK_GRAPHICS_COLS  = 4'hA;
    localparam logic [3:0] IDX_BLOCK_GRAPHICS_ROWS  = 4'hB;
    localparam logic [3:0] IDX_UNDERLINE_SCAN_RANGE = 4'hC;
    localparam logic [3:0] IDX_CURSOR_SCAN_RANGE    = 4'hD;
    localparam logic [3:0] IDX_CURSOR_ADDRESS       = 4'hE;
    localparam logic [3:0] IDX_CHAIN_STATUS         = 4'hF;
    localparam int         IDX_LSB                  = 2;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int ROW_W      = 5;
    localparam int SCAN_W     = 4;
    localparam int ADDR_W     = 16;
    localparam int NIB_HI_LSB = 4;
    localparam int RATE_LSB   = 3;
    localparam int RATE_W     = 5;
    localparam int DUTY_W     = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]        RST_BYTE = 8'h00;
    localparam logic [ROW_W-1:0]  RST_ROW  = 5'h00;
    localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;

    // ------------------------------------------------------------
    // ahb-lite encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // timing counts: one character time is one clock
    localparam int CHAR_TIME_CYCLES = 1;

    // frame phase: displayed and retrace rows, then extra scans
    typedef enum logic [0:0] {ST_ROWS, ST_EXTRA} frame_phase_e;

    // blink divider configuration
    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic [DUTY_W-1:0] duty;
    } blink_cfg_s;

endpackage
